// file: rtl/alarm_params.svh
// constants for the drive alarm supervisor
`ifndef ALARM_PARAMS_SVH
`define ALARM_PARAMS_SVH
`define ALM_NONE        16'h0000
`define ALM_OVERSPEED   16'h0001
`define ALM_MISS_PULSE  16'h0002
`define ALM_FIELD_OVI   16'h0004
`define ALM_HEATSINK    16'h0008
`define ALM_THERMISTOR  16'h0010
`define ALM_ARM_OVV     16'h0020
`define ALM_SPEED_FBK   16'h0040
`define ALM_ENCODER     16'h0080
`define ALM_FIELD_FAIL  16'h0100
`define ALM_THREE_PHASE 16'h0200
`define ALM_PHASE_LOCK  16'h0400
`define ALM_LINK_RX     16'h0800
`define ALM_STALL       16'h1000
`define ALM_OVERCURRENT 16'h2000
`define ALM_CT_FAIL     16'h8000
`define ALM_EXT_TRIP    16'hf005
`define ALM_AT_ERROR    16'hf001
`define ALM_AT_ABORT    16'hf002
`define ALM_CFG_EN      16'hf200
`define ALM_NO_OPSTN    16'hf400
`define ALM_REM_TRIP    16'hf006
`define ALM_BOARD_VER   16'hff05
`define ALM_PRODUCT     16'hff06
// field loss thresholds in percent of rated field current
`define FLD_MIN_PCT_CUR 8'd6
`define FLD_MIN_PCT_VLT 8'd12
// delay setting is in tenths of a second
`define DELAY_UNIT_MS   32'd100
`define CLK_HZ          32'd20000000
`define DELAY_MIN_TENTH 13'd1
`define DELAY_MAX_TENTH 13'd6000
`define SYNC_ZERO       3'b000
`endif

// file: rtl/alarm_pkg.sv
// types for the drive alarm supervisor
package alarm_pkg;
  typedef enum logic [2:0] {
    TR_IDLE  = 3'b001,
    TR_DELAY = 3'b010,
    TR_TRIP  = 3'b100
  } trip_state_t;
endpackage : alarm_pkg

// file: rtl/input_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module input_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // raw and filtered levels
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] clean_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clean_q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          clean_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : input_sync

// file: rtl/drive_alarm_supervisor.sv
// alarm collection, latching, masking and trip for the drive
//
// Functional notes
// - summary word ORs codes of present alarms
// - first alarm code held until faults clear
// - latest alarm code kept; zero means none
// - low byte alarms are single bits
// - high byte alarms are single bits
// - non-bitmask codes for special alarms
// - stall: current high, zero speed, not setpoint
// - stall status bit, one means failed
// - field loss mask one suppresses alarm
// - field loss below 6 or 12 percent
// - link rx error only counts in slave
// - stall mask stops stall opening contactor
// - speed feedback mask suppresses alarm
// - encoder alarm needs encoder selected, unmasked
// - external fault mask blocks remote trip, not status bit
// - remote fault trips after programmed delay
// - no auto clear: faults stay latched
// - auto clear resets faults on run falling low
// - remote fault state as status bit
`timescale 1ns/1ns
`include "alarm_params.svh"
module drive_alarm_supervisor
  import alarm_pkg::*;
#(
  parameter int TICKS_PER_TENTH = `CLK_HZ / 32'd1000 * `DELAY_UNIT_MS
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // fault detector pins
  input  wire logic        overspeed_in,
  input  wire logic        missing_pulse_in,
  input  wire logic        field_overcurrent_in,
  input  wire logic        heatsink_in,
  input  wire logic        thermistor_in,
  input  wire logic        armature_overvolt_in,
  input  wire logic        speed_feedback_in,
  input  wire logic        encoder_error_in,
  input  wire logic        three_phase_in,
  input  wire logic        phase_lock_in,
  input  wire logic        serial_rx_error_in,
  input  wire logic        overcurrent_in,
  input  wire logic        ct_fail_in,
  input  wire logic        external_fault_in,
  input  wire logic        zero_speed_flag,
  input  wire logic        zero_setpoint_flag,
  input  wire logic        run_command_terminal,
  // analogue compares, same clock
  input  wire logic [7:0]  field_current_pct,
  input  wire logic        current_ctrl_mode,
  input  wire logic        stall_current_over,
  // configuration
  input  wire logic        field_fail_mask,
  input  wire logic        serial_link_rx_error_mask,
  input  wire logic        serial_slave_mode,
  input  wire logic        stall_mask,
  input  wire logic        speed_feedback_mask,
  input  wire logic        encoder_mask,
  input  wire logic        encoder_selected,
  input  wire logic        external_fault_mask,
  input  wire logic [12:0] external_fault_delay,
  input  wire logic        auto_fault_clear,
  // status and contactor
  output logic [15:0]      alarm_summary_word,
  output logic [15:0]      first_fault_code,
  output logic [15:0]      latest_alarm_code,
  output logic             stall_status,
  output logic             external_fault_status,
  output logic             contactor_close,
  output logic             drive_ok_output
);
  localparam int NPIN = 15;
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] pins;
  logic [15:0]     live;
  logic [15:0]     live_trip;
  logic [15:0]     latched_q;
  logic [15:0]     newbits;
  logic            stall_now;
  logic            field_loss;
  logic            ext_trip_now;
  logic            trip_any;
  logic            clear_now;
  logic            run_q;
  logic [31:0]     tick_q;
  logic [12:0]     tenth_q;
  trip_state_t     tr_q;

  // lowest set bit code, used for first and latest capture
  function automatic logic [15:0] lowest_code(input logic [15:0] v);
    logic [15:0] r;
    r = `ALM_NONE;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = `ALM_OVERSPEED << i;
      end
    end
    return r;
  endfunction : lowest_code

  assign pins_raw = {external_fault_in, run_command_terminal,
                     zero_setpoint_flag, zero_speed_flag, ct_fail_in,
                     overcurrent_in, serial_rx_error_in, phase_lock_in,
                     three_phase_in, encoder_error_in, speed_feedback_in,
                     armature_overvolt_in, thermistor_in, heatsink_in,
                     field_overcurrent_in};

  input_sync #(.WIDTH(NPIN)) u_sync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .raw     (pins_raw),
    .clean_q (pins)
  );

  logic ovs_s;
  logic mp_s;
  input_sync #(.WIDTH(2)) u_sync2 (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .raw     ({missing_pulse_in, overspeed_in}),
    .clean_q ({mp_s, ovs_s})
  );

  assign stall_now = stall_current_over && pins[11]
                     && !pins[12];
  assign field_loss = current_ctrl_mode
      ? (field_current_pct < `FLD_MIN_PCT_CUR)
      : (field_current_pct < `FLD_MIN_PCT_VLT);

  // present alarms, each at its own code
  always_comb begin
    live = `ALM_NONE;
    if (ovs_s) live = live | `ALM_OVERSPEED;
    if (mp_s) live = live | `ALM_MISS_PULSE;
    if (pins[0]) live = live | `ALM_FIELD_OVI;
    if (pins[1]) live = live | `ALM_HEATSINK;
    if (pins[2]) live = live | `ALM_THERMISTOR;
    if (pins[3]) live = live | `ALM_ARM_OVV;
    if (pins[4] && !speed_feedback_mask)
      live = live | `ALM_SPEED_FBK;
    if (pins[5] && encoder_selected && !encoder_mask)
      live = live | `ALM_ENCODER;
    if (field_loss && !field_fail_mask)
      live = live | `ALM_FIELD_FAIL;
    if (pins[6]) live = live | `ALM_THREE_PHASE;
    if (pins[7]) live = live | `ALM_PHASE_LOCK;
    if (serial_slave_mode && pins[8] && !serial_link_rx_error_mask)
      live = live | `ALM_LINK_RX;
    if (stall_now) live = live | `ALM_STALL;
    if (pins[9]) live = live | `ALM_OVERCURRENT;
    if (pins[10]) live = live | `ALM_CT_FAIL;
  end

  // stall is reported but may not trip
  assign live_trip = stall_mask ? (live & ~`ALM_STALL) : live;
  assign newbits = live_trip & ~latched_q;
  assign ext_trip_now = (tr_q == TR_TRIP);
  assign trip_any = (latched_q != `ALM_NONE) || ext_trip_now;
  // clearing needs auto clear set and run falling low
  assign clear_now = auto_fault_clear && run_q && !pins[13];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
    end else begin
      run_q <= pins[13];
    end
  end

  // latched faults; a new fault beats a clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latched_q <= `ALM_NONE;
    end else if (clear_now) begin
      latched_q <= live_trip;
    end else begin
      latched_q <= latched_q | live_trip;
    end
  end

  // delay counter for the remote fault
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tr_q    <= TR_IDLE;
      tick_q  <= 32'h0000_0000;
      tenth_q <= 13'h0000;
    end else begin
      case (tr_q)
        TR_IDLE: begin
          tick_q  <= 32'h0000_0000;
          tenth_q <= 13'h0000;
          if (pins[14] && !external_fault_mask) tr_q <= TR_DELAY;
        end
        TR_DELAY: begin
          if (!pins[14] || external_fault_mask) begin
            tr_q <= TR_IDLE;
          end else if (tick_q == 32'(TICKS_PER_TENTH - 1)) begin
            tick_q  <= 32'h0000_0000;
            tenth_q <= tenth_q + 13'h0001;
            if (tenth_q + 13'h0001 >= external_fault_delay
                || tenth_q + 13'h0001 >= `DELAY_MAX_TENTH)
              tr_q <= TR_TRIP;
          end else begin
            tick_q <= tick_q + 32'h0000_0001;
          end
        end
        TR_TRIP: begin
          if (clear_now && !pins[14]) tr_q <= TR_IDLE;
        end
        default: tr_q <= TR_IDLE;
      endcase
    end
  end

  // status words
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_summary_word    <= `ALM_NONE;
      stall_status          <= 1'b0;
      external_fault_status <= 1'b0;
    end else begin
      alarm_summary_word    <= live;
      stall_status          <= stall_now;
      external_fault_status <= pins[14];
    end
  end

  // first and latest codes; ties resolve to lowest bit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      first_fault_code  <= `ALM_NONE;
      latest_alarm_code <= `ALM_NONE;
    end else begin
      if (clear_now) begin
        first_fault_code  <= lowest_code(live_trip);
        latest_alarm_code <= lowest_code(live_trip);
      end else if (newbits != `ALM_NONE) begin
        if (first_fault_code == `ALM_NONE)
          first_fault_code <= lowest_code(newbits);
        latest_alarm_code <= lowest_code(newbits);
      end else if (tr_q == TR_DELAY && pins[14] && !external_fault_mask
                   && tick_q == 32'(TICKS_PER_TENTH - 1)
                   && (tenth_q + 13'h0001 >= external_fault_delay
                       || tenth_q + 13'h0001 >= `DELAY_MAX_TENTH)) begin
        if (first_fault_code == `ALM_NONE)
          first_fault_code <= `ALM_REM_TRIP;
        latest_alarm_code <= `ALM_REM_TRIP;
      end
    end
  end

  // contactor and drive ok follow the trip state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      contactor_close <= 1'b0;
      drive_ok_output <= 1'b0;
    end else begin
      contactor_close <= pins[13] && !trip_any && (live_trip == `ALM_NONE);
      drive_ok_output <= !trip_any && (live_trip == `ALM_NONE);
    end
  end

  a_stall_status: assert property (@(posedge mclk) disable iff (!rst_b)
    stall_now |=> stall_status)
    else $error("stall status missed");
  a_summary_word: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |=> alarm_summary_word == $past(live))
    else $error("summary word wrong");
  a_first_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (first_fault_code != `ALM_NONE && !clear_now)
    |=> $stable(first_fault_code))
    else $error("first fault changed");
  a_trip_drops_ok: assert property (@(posedge mclk) disable iff (!rst_b)
    (live_trip != `ALM_NONE) |=> !drive_ok_output && !contactor_close)
    else $error("trip did not drop ok");
  a_stall_masked: assert property (@(posedge mclk) disable iff (!rst_b)
    stall_mask |-> !live_trip[12])
    else $error("masked stall trips");
  a_ext_masked: assert property (@(posedge mclk) disable iff (!rst_b)
    (tr_q == TR_IDLE && external_fault_mask) |=> tr_q == TR_IDLE)
    else $error("masked remote fault");
  a_latch_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (!auto_fault_clear && latched_q != `ALM_NONE)
    |=> latched_q != `ALM_NONE ##0 !drive_ok_output)
    else $error("fault cleared without auto clear");
  a_rx_slave: assert property (@(posedge mclk) disable iff (!rst_b)
    !serial_slave_mode |-> !live[11])
    else $error("rx error outside slave");
  a_ext_status: assert property (@(posedge mclk) disable iff (!rst_b)
    pins[14] |=> external_fault_status)
    else $error("remote status missed");
  c_stall: cover property (@(posedge mclk) disable iff (!rst_b)
    stall_now ##1 stall_status);
  c_ext_trip: cover property (@(posedge mclk) disable iff (!rst_b)
    tr_q == TR_DELAY ##1 tr_q == TR_TRIP);
  c_clear: cover property (@(posedge mclk) disable iff (!rst_b)
    clear_now ##1 drive_ok_output);
endmodule : drive_alarm_supervisor

// file: tb/fault_source.sv
// far-side model: fault detectors and run command pins
`timescale 1ns/1ns
module fault_source (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // requested pin levels
  input  wire logic [16:0] req,
  // contactor sense
  input  wire logic        contactor_close,
  // pins toward the supervisor
  output logic      [16:0] pins
);
  // detectors settle one clock after the request, like real comparators
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pins <= 17'h00000;
    end else begin
      pins <= req;
    end
  end
endmodule : fault_source

// file: tb/testbench.sv
// self-checking bench for the drive alarm supervisor
`timescale 1ns/1ns
module testbench;
  logic mclk, rst_b, zero_speed_flag, zero_setpoint_flag, run_command_terminal;
  logic overspeed_in, missing_pulse_in, field_overcurrent_in, heatsink_in;
  logic thermistor_in, armature_overvolt_in, speed_feedback_in;
  logic encoder_error_in, three_phase_in, phase_lock_in, serial_rx_error_in;
  logic overcurrent_in, ct_fail_in, external_fault_in, current_ctrl_mode;
  logic stall_current_over, field_fail_mask, serial_link_rx_error_mask;
  logic serial_slave_mode, stall_mask, speed_feedback_mask, encoder_mask;
  logic encoder_selected, external_fault_mask, auto_fault_clear;
  logic stall_status, external_fault_status, contactor_close;
  logic drive_ok_output;
  logic [7:0]  field_current_pct;
  logic [12:0] external_fault_delay;
  logic [15:0] alarm_summary_word, first_fault_code, latest_alarm_code;
  logic [16:0] req, pins;
  logic [15:0] codes [13] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
    16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0200, 16'h0400, 16'h0800,
    16'h2000, 16'h8000};
  int num_errors = 0;
  int checks = 0;

  assign {run_command_terminal, zero_setpoint_flag, zero_speed_flag,
    external_fault_in, ct_fail_in, overcurrent_in, serial_rx_error_in,
    phase_lock_in, three_phase_in, encoder_error_in, speed_feedback_in,
    armature_overvolt_in, thermistor_in, heatsink_in, field_overcurrent_in,
    missing_pulse_in, overspeed_in} = pins;

  fault_source far_u (.mclk, .rst_b, .req, .contactor_close, .pins);

  // short tick so the remote delay runs in about nine cycles
  drive_alarm_supervisor #(.TICKS_PER_TENTH(4)) dut_u (
    .mclk, .rst_b, .overspeed_in, .missing_pulse_in, .field_overcurrent_in,
    .heatsink_in, .thermistor_in, .armature_overvolt_in, .speed_feedback_in,
    .encoder_error_in, .three_phase_in, .phase_lock_in, .serial_rx_error_in,
    .overcurrent_in, .ct_fail_in, .external_fault_in, .zero_speed_flag,
    .zero_setpoint_flag, .run_command_terminal, .field_current_pct,
    .current_ctrl_mode, .stall_current_over, .field_fail_mask,
    .serial_link_rx_error_mask, .serial_slave_mode, .stall_mask,
    .speed_feedback_mask, .encoder_mask, .encoder_selected,
    .external_fault_mask, .external_fault_delay, .auto_fault_clear,
    .alarm_summary_word, .first_fault_code, .latest_alarm_code,
    .stall_status, .external_fault_status, .contactor_close,
    .drive_ok_output);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // sampled one ns after the edge so its updates have landed
  task automatic wt(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt

  // pin path: bench reg, model reg, three-stage sync, agree, output
  task automatic pin(int idx, logic v);
    @(posedge mclk);
    req[idx] <= v;
    wt(8);
  endtask : pin

  task automatic clr;
    pin(16, 1'b1);
    pin(16, 1'b0);
  endtask : clr

  task automatic quiet(int idx);
    pin(idx, 1'b1);
    chk("summary", 16'h0000, alarm_summary_word);
    chk("drive_ok", 16'h0001, {15'h0000, drive_ok_output});
    pin(idx, 1'b0);
  endtask : quiet

  task automatic fld(logic mode, logic [7:0] pct, logic msk, logic [15:0] e);
    @(posedge mclk);
    current_ctrl_mode <= mode;
    field_current_pct <= pct;
    field_fail_mask   <= msk;
    wt(4);
    chk("field summary", e, alarm_summary_word);
    @(posedge mclk);
    field_current_pct <= 8'd50;
    clr();
  endtask : fld

  initial begin
    #(50 * 5000);
    num_errors++;
    complete_run();
  end

  initial begin
    rst_b = 1'b0;
    req = 17'h00000;
    {field_fail_mask, serial_link_rx_error_mask, stall_mask} = 3'b000;
    {speed_feedback_mask, encoder_mask, external_fault_mask} = 3'b000;
    {encoder_selected, serial_slave_mode, auto_fault_clear} = 3'b111;
    stall_current_over = 1'b0;
    current_ctrl_mode = 1'b1;
    field_current_pct = 8'd50;
    external_fault_delay = 13'd2;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    wt(8);
    chk("summary", 16'h0000, alarm_summary_word);
    chk("latest", 16'h0000, latest_alarm_code);
    pin(16, 1'b1);
    chk("contactor", 16'h0001, {15'h0000, contactor_close});
    pin(16, 1'b0);
    for (int i = 0; i < 13; i++) begin
      pin(i, 1'b1);
      chk("summary", codes[i], alarm_summary_word);
      chk("first", codes[i], first_fault_code);
      chk("latest", codes[i], latest_alarm_code);
      chk("drive_ok", 16'h0000, {15'h0000, drive_ok_output});
      chk("contactor", 16'h0000, {15'h0000, contactor_close});
      pin(i, 1'b0);
      clr();
      chk("drive_ok", 16'h0001, {15'h0000, drive_ok_output});
      chk("latest", 16'h0000, latest_alarm_code);
    end
    pin(3, 1'b1);
    pin(0, 1'b1);
    chk("summary", 16'h0009, alarm_summary_word);
    chk("first", 16'h0008, first_fault_code);
    chk("latest", 16'h0001, latest_alarm_code);
    pin(3, 1'b0);
    pin(0, 1'b0);
    clr();
    fld(1'b1, 8'd5, 1'b1, 16'h0000);
    fld(1'b1, 8'd5, 1'b0, 16'h0100);
    fld(1'b1, 8'd10, 1'b0, 16'h0000);
    fld(1'b0, 8'd10, 1'b0, 16'h0100);
    @(posedge mclk);
    speed_feedback_mask <= 1'b1;
    encoder_mask <= 1'b1;
    serial_slave_mode <= 1'b0;
    external_fault_mask <= 1'b1;
    quiet(6);
    quiet(7);
    quiet(10);
    quiet(13);
    @(posedge mclk);
    encoder_mask <= 1'b0;
    encoder_selected <= 1'b0;
    serial_slave_mode <= 1'b1;
    serial_link_rx_error_mask <= 1'b1;
    quiet(7);
    quiet(10);
    @(posedge mclk);
    external_fault_mask <= 1'b0;
    pin(13, 1'b1);
    chk("ext status", 16'h0001, {15'h0000, external_fault_status});
    chk("drive_ok", 16'h0001, {15'h0000, drive_ok_output});
    wt(12);
    chk("latest", 16'hf006, latest_alarm_code);
    chk("drive_ok", 16'h0000, {15'h0000, drive_ok_output});
    pin(13, 1'b0);
    clr();
    @(posedge mclk);
    stall_current_over <= 1'b1;
    pin(14, 1'b1);
    chk("summary", 16'h1000, alarm_summary_word);
    chk("stall", 16'h0001, {15'h0000, stall_status});
    chk("drive_ok", 16'h0000, {15'h0000, drive_ok_output});
    @(posedge mclk);
    stall_current_over <= 1'b0;
    clr();
    @(posedge mclk);
    stall_mask <= 1'b1;
    stall_current_over <= 1'b1;
    wt(4);
    chk("summary", 16'h1000, alarm_summary_word);
    chk("drive_ok", 16'h0001, {15'h0000, drive_ok_output});
    pin(15, 1'b1);
    chk("stall", 16'h0000, {15'h0000, stall_status});
    @(posedge mclk);
    stall_current_over <= 1'b0;
    pin(14, 1'b0);
    @(posedge mclk);
    auto_fault_clear <= 1'b0;
    pin(3, 1'b1);
    pin(3, 1'b0);
    clr();
    chk("drive_ok", 16'h0000, {15'h0000, drive_ok_output});
    chk("latest", 16'h0008, latest_alarm_code);
    @(posedge mclk);
    auto_fault_clear <= 1'b1;
    clr();
    chk("drive_ok", 16'h0001, {15'h0000, drive_ok_output});
    complete_run();
  end
endmodule : testbench
